/* File: lpbi_core.sv */
// Nine-output PWM intensity and blink-phase level logic with register port
//
// Summary of operation
// - Phase-zero register sets outputs seven..zero levels
// - Phase-one register sets levels in phase one
// - Master below 0x10 makes all outputs static
// - Oscillator stops when PWM disabled everywhere
// - Period is 15 timeslots of 16 steps
// - Master gates 1 to 15 timeslots
// - Four-bit intensity gives 1/16..16/16 duty in-slot
// - Setting 16/16 gives static blink-phase level
// - Blink off: phase-zero bit gives on-time level
// - Phase bit picks duty range polarity
// - Blink on: phase selects level register
// - Ninth intensity doubles as global setting
// - Global applies to all; mixing needs individual
// - Global mode ignores per-output intensity registers
// - Global flag: master low nibble sets intensity
// - Blink phase is flip XOR blink pin
// - Ninth output levels from configuration bits
`timescale 1ns/1ps
module lpbi_core #(
	parameter int TICKS = lpbi_pkg::TICK_CYCLES  // Clocks per oscillator step
) (
	// Clock and reset
	input  wire logic                            mclk,
	input  wire logic                            rst,
	// Register port
	input  wire lpbi_pkg::lpbi_req_t             req,
	output logic [7:0]                           rdData,
	output logic                                 rdValid,
	// Blink pin
	input  wire logic                            blinkPin,
	// Open-drain outputs
	output logic [lpbi_pkg::NUM_OUT-1:0]         outDrv,
	output logic [lpbi_pkg::NUM_OUT-1:0]         outOe
);

	// ----------------------------------------------------------------
	// State and helpers
	// ----------------------------------------------------------------
	lpbi_pkg::lpbi_state_t st;      // Registered state
	lpbi_pkg::lpbi_state_t stNext;  // Next state

	logic                         tick;       // Oscillator step
	logic [3:0]                   slotIdx;    // Current timeslot
	logic [3:0]                   cycleIdx;   // Current cycle in slot
	logic                         pwmOn;      // PWM enabled at all
	logic                         globalOn;   // Global intensity mode
	logic                         phaseOne;   // Blink phase one active
	logic [3:0]                   masterSlots;  // Gated timeslot count
	logic [3:0]                   masterLow;  // Ninth or global intensity
	logic [lpbi_pkg::NUM_OUT-1:0] level;      // Next output levels

	assign masterSlots = st.master[7:4];
	assign masterLow   = st.master[3:0];
	assign pwmOn       = (masterSlots != lpbi_pkg::PWM_OFF);
	assign globalOn    = st.cfg[lpbi_pkg::CFG_GLOBAL];
	// Phase zero unless blinking; then flip flag XOR synchronised pin
	assign phaseOne    = st.cfg[lpbi_pkg::CFG_BLINK_EN] &
	                     (st.cfg[lpbi_pkg::CFG_BLINK_FLIP] ^ st.pinS2);

	// ----------------------------------------------------------------
	// Oscillator and timeslot counter
	// ----------------------------------------------------------------
	lpbi_slot_counter #(
		.TICKS    (TICKS)
	) uCounter (
		.mclk     (mclk),
		.rst      (rst),
		.run      (pwmOn),
		.tick     (tick),
		.slotIdx  (slotIdx),
		.cycleIdx (cycleIdx)
	);

	// ----------------------------------------------------------------
	// Per-output level
	// ----------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < lpbi_pkg::NUM_OUT; k++) begin : gOut
			logic [3:0] inten;  // Effective intensity
			logic       ph;     // Blink-phase level
			logic       onTime; // Inside PWM on-time
			if (k < lpbi_pkg::NUM_OUT - 1) begin : gPort
				// Global mode uses only the master register
				assign inten = globalOn ? masterLow :
				               st.inten[k*4 +: 4];
				assign ph = phaseOne ? st.phase1[k] : st.phase0[k];
			end else begin : gNinth
				// Ninth intensity is the master low nibble in both modes
				assign inten = masterLow;
				assign ph = phaseOne ? st.cfg[lpbi_pkg::CFG_NINTH_P1] :
				            st.cfg[lpbi_pkg::CFG_NINTH_P0];
			end
			// On while in a gated slot and within (inten+1)/16 of it
			assign onTime = (slotIdx < masterSlots) && (cycleIdx <= inten);
			// Static level when PWM off or 16/16; otherwise inverted off-time
			assign level[k] = (!pwmOn || inten == lpbi_pkg::FULL_ON) ? ph :
			                  (onTime ? ph : ~ph);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Next-state logic: register port, synchroniser, outputs
	// ----------------------------------------------------------------
	always_comb begin
		stNext         = st;
		stNext.pinS1   = blinkPin;
		stNext.pinS2   = st.pinS1;
		stNext.rdValid = req.rd;
		stNext.drv     = '0;
		// High level releases the pin; low level sinks it
		stNext.oe      = ~level;
		// Register writes
		if (req.wr) begin
			case (req.addr)
				lpbi_pkg::ADDR_PHASE0: begin
					stNext.phase0 = req.data;
				end
				lpbi_pkg::ADDR_PHASE1: begin
					stNext.phase1 = req.data;
				end
				lpbi_pkg::ADDR_MASTER: begin
					stNext.master = req.data;
				end
				lpbi_pkg::ADDR_CONFIG: begin
					stNext.cfg = req.data;
				end
				default: begin
					if (req.addr >= lpbi_pkg::ADDR_INT_BASE &&
					    req.addr <= lpbi_pkg::ADDR_INT_LAST) begin
						stNext.inten[req.addr[1:0]*8 +: 8] = req.data;
					end
				end
			endcase
		end
		// Register reads; unmapped addresses answer zero
		stNext.rdData = lpbi_pkg::RD_ZERO;
		if (req.rd) begin
			case (req.addr)
				lpbi_pkg::ADDR_PHASE0: begin
					stNext.rdData = st.phase0;
				end
				lpbi_pkg::ADDR_PHASE1: begin
					stNext.rdData = st.phase1;
				end
				lpbi_pkg::ADDR_MASTER: begin
					stNext.rdData = st.master;
				end
				lpbi_pkg::ADDR_CONFIG: begin
					stNext.rdData = {1'b0, st.pinS2, st.cfg[5:4], 1'b0, st.cfg[2:0]};
				end
				default: begin
					if (req.addr >= lpbi_pkg::ADDR_INT_BASE &&
					    req.addr <= lpbi_pkg::ADDR_INT_LAST) begin
						stNext.rdData = st.inten[req.addr[1:0]*8 +: 8];
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			st.phase0  <= lpbi_pkg::RST_PHASE;
			st.phase1  <= lpbi_pkg::RST_PHASE;
			st.cfg     <= lpbi_pkg::RST_CONFIG;
			st.master  <= lpbi_pkg::RST_MASTER;
			st.inten   <= {lpbi_pkg::NUM_INT{lpbi_pkg::RST_INT}};
			st.pinS1   <= 1'b0;
			st.pinS2   <= 1'b0;
			st.rdData  <= lpbi_pkg::RD_ZERO;
			st.rdValid <= 1'b0;
			st.drv     <= '0;
			st.oe      <= '0;
		end else begin
			st <= stNext;
		end
	end

	assign rdData  = st.rdData;
	assign rdValid = st.rdValid;
	assign outDrv  = st.drv;
	assign outOe   = st.oe;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Write to an address, one idle cycle, then a read of it
	sequence s_wrRd(logic [7:0] a);
		(req.wr && !req.rd && req.addr == a) ##1 (!req.wr && !req.rd) ##1
		(req.rd && !req.wr && req.addr == a);
	endsequence

	property p_phase0Back;
		@(posedge mclk) disable iff (rst)
		s_wrRd(lpbi_pkg::ADDR_PHASE0) |=> (rdValid && rdData == $past(req.data, 3));
	endproperty
	a_phase0Back: assert property (p_phase0Back) else $error("phase0 readback wrong");

	property p_phase1Back;
		@(posedge mclk) disable iff (rst)
		s_wrRd(lpbi_pkg::ADDR_PHASE1) |=> (rdValid && rdData == $past(req.data, 3));
	endproperty
	a_phase1Back: assert property (p_phase1Back) else $error("phase1 readback wrong");

	property p_staticOff;
		@(posedge mclk) disable iff (rst)
		(!pwmOn && !phaseOne) |=> (outOe[7:0] == ~$past(st.phase0));
	endproperty
	a_staticOff: assert property (p_staticOff) else $error("static level wrong");

	property p_oscStop;
		@(posedge mclk) disable iff (rst)
		(!pwmOn ##1 !pwmOn) |-> !tick;
	endproperty
	a_oscStop: assert property (p_oscStop) else $error("oscillator runs with PWM off");

	property p_wrap;
		@(posedge mclk) disable iff (rst)
		(tick && slotIdx == 4'h0 && cycleIdx == 4'h0) |->
		($past(slotIdx) == lpbi_pkg::SLOT_LAST && $past(cycleIdx) == lpbi_pkg::CYCLE_LAST);
	endproperty
	a_wrap: assert property (p_wrap) else $error("period wrap wrong");

	property p_onTime;
		@(posedge mclk) disable iff (rst)
		(pwmOn && !globalOn && !phaseOne && slotIdx < masterSlots &&
		 cycleIdx <= st.inten[3:0]) |=> (outOe[0] == ~$past(st.phase0[0]));
	endproperty
	a_onTime: assert property (p_onTime) else $error("on-time level wrong");

	property p_gateOff;
		@(posedge mclk) disable iff (rst)
		(pwmOn && !globalOn && !phaseOne && slotIdx >= masterSlots &&
		 st.inten[3:0] != lpbi_pkg::FULL_ON) |=> (outOe[0] == $past(st.phase0[0]));
	endproperty
	a_gateOff: assert property (p_gateOff) else $error("gated slot not off");

	property p_fullOn;
		@(posedge mclk) disable iff (rst)
		(pwmOn && !globalOn && !phaseOne && st.inten[7:4] == lpbi_pkg::FULL_ON)
		|=> (outOe[1] == ~$past(st.phase0[1]));
	endproperty
	a_fullOn: assert property (p_fullOn) else $error("16/16 not static");

	property p_blinkPhase;
		@(posedge mclk) disable iff (rst)
		(!pwmOn && st.cfg[lpbi_pkg::CFG_BLINK_EN] &&
		 (st.cfg[lpbi_pkg::CFG_BLINK_FLIP] ^ st.pinS2)) |=> (outOe[7:0] == ~$past(st.phase1));
	endproperty
	a_blinkPhase: assert property (p_blinkPhase) else $error("phase one not used");

	property p_global;
		@(posedge mclk) disable iff (rst)
		(pwmOn && globalOn && !phaseOne && slotIdx >= masterSlots &&
		 masterLow != lpbi_pkg::FULL_ON) |=> (outOe[7:0] == $past(st.phase0));
	endproperty
	a_global: assert property (p_global) else $error("global mode wrong");

	property p_ninth;
		@(posedge mclk) disable iff (rst)
		(!pwmOn && !phaseOne) |=> (outOe[8] == ~$past(st.cfg[lpbi_pkg::CFG_NINTH_P0]));
	endproperty
	a_ninth: assert property (p_ninth) else $error("ninth level wrong");

	// Ninth output outside its gated slots shows the inverted phase level
	property p_ninthOff;
		@(posedge mclk) disable iff (rst)
		(pwmOn && !phaseOne && slotIdx >= masterSlots && masterLow != lpbi_pkg::FULL_ON)
		|=> (outOe[8] == $past(st.cfg[lpbi_pkg::CFG_NINTH_P0]));
	endproperty
	a_ninthOff: assert property (p_ninthOff) else $error("ninth off-time wrong");

	// Global on-time drives every port to its phase-zero level
	property p_globalOn;
		@(posedge mclk) disable iff (rst)
		(pwmOn && globalOn && !phaseOne && slotIdx < masterSlots && cycleIdx <= masterLow)
		|=> (outOe[7:0] == ~$past(st.phase0));
	endproperty
	a_globalOn: assert property (p_globalOn) else $error("global on-time wrong");

	// Phase bit low: the pin sinks during its on-time
	property p_lowRange;
		@(posedge mclk) disable iff (rst)
		(pwmOn && !globalOn && !phaseOne && !st.phase0[4] && slotIdx < masterSlots &&
		 cycleIdx <= st.inten[19:16]) |=> outOe[4];
	endproperty
	a_lowRange: assert property (p_lowRange) else $error("low phase bit not sinking");

	// Counters hold while the oscillator is stopped
	property p_hold;
		@(posedge mclk) disable iff (rst)
		!pwmOn |=> ($stable(slotIdx) && $stable(cycleIdx));
	endproperty
	a_hold: assert property (p_hold) else $error("counter moved while stopped");

	// The cycle index moves only on an oscillator step
	property p_step;
		@(posedge mclk) disable iff (rst)
		$changed(cycleIdx) |-> tick;
	endproperty
	a_step: assert property (p_step) else $error("cycle moved without a step");

	// A read strobe is answered in the next cycle
	property p_rdAnswer;
		@(posedge mclk) disable iff (rst)
		req.rd |=> rdValid;
	endproperty
	a_rdAnswer: assert property (p_rdAnswer) else $error("read not answered");

	// Without a read the answer port rests at zero
	property p_rdIdle;
		@(posedge mclk) disable iff (rst)
		!req.rd |=> (!rdValid && rdData == lpbi_pkg::RD_ZERO);
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("read port not idle");

endmodule

/* File: lpbi_pkg.sv */
// Package with register map, field positions, timing constants and carrier types
package lpbi_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_PHASE0   = 8'h01;  // Phase-zero level register
	localparam logic [7:0] ADDR_PHASE1   = 8'h09;  // Phase-one level register
	localparam logic [7:0] ADDR_MASTER   = 8'h0E;  // Master and ninth-output intensity
	localparam logic [7:0] ADDR_CONFIG   = 8'h0F;  // Configuration register
	localparam logic [7:0] ADDR_INT_BASE = 8'h10;  // First individual intensity register
	localparam logic [7:0] ADDR_INT_LAST = 8'h13;  // Last individual intensity register

	// ----------------------------------------------------------------
	// Configuration register fields
	// ----------------------------------------------------------------
	localparam int CFG_BLINK_EN   = 0;  // Blink enable flag
	localparam int CFG_BLINK_FLIP = 1;  // Blink flip flag
	localparam int CFG_GLOBAL     = 2;  // Global intensity flag
	localparam int CFG_NINTH_P0   = 4;  // Ninth output level in phase zero
	localparam int CFG_NINTH_P1   = 5;  // Ninth output level in phase one
	localparam int CFG_PIN_STAT   = 6;  // Blink pin status, read only

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] RST_PHASE  = 8'hFF;  // Outputs released after reset
	localparam logic [7:0] RST_CONFIG = 8'h30;  // Ninth output released in both phases
	localparam logic [7:0] RST_MASTER = 8'h00;  // PWM off after reset
	localparam logic [7:0] RST_INT    = 8'h00;  // Individual intensity reset value
	localparam logic [7:0] RD_ZERO    = 8'h00;  // Answer to an unmapped read

	// ----------------------------------------------------------------
	// PWM period shape
	// ----------------------------------------------------------------
	localparam logic [3:0] SLOT_LAST  = 4'hE;  // Fifteen timeslots, 0..14
	localparam logic [3:0] CYCLE_LAST = 4'hF;  // Sixteen cycles per timeslot
	localparam logic [3:0] FULL_ON    = 4'hF;  // Intensity 16/16, static output
	localparam logic [3:0] PWM_OFF    = 4'h0;  // Master slot nibble that disables PWM
	localparam int         NUM_OUT    = 9;     // Number of outputs
	localparam int         NUM_INT    = 4;     // Individual intensity registers

	// ----------------------------------------------------------------
	// Oscillator timing
	// ----------------------------------------------------------------
	localparam int OSC_HZ      = 32000;                // Nominal PWM oscillator
	localparam int CLK_PER_NS  = 20;                   // System clock period
	localparam int OSC_PER_NS  = 1000000000 / OSC_HZ;  // Oscillator period in ns
	localparam int TICK_CYCLES = OSC_PER_NS / CLK_PER_NS;  // Clocks per step

	// ----------------------------------------------------------------
	// Carrier types
	// ----------------------------------------------------------------
	// Register access request
	typedef struct packed {
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
		logic [7:0] addr;  // Register address
		logic [7:0] data;  // Write data
	} lpbi_req_t;

	// Complete state of the main block
	typedef struct packed {
		logic [7:0]         phase0;   // Phase-zero levels
		logic [7:0]         phase1;   // Phase-one levels
		logic [7:0]         cfg;      // Configuration bits
		logic [7:0]         master;   // Master slots and ninth intensity
		logic [31:0]        inten;    // Four packed intensity registers
		logic               pinS1;    // Blink pin, first stage
		logic               pinS2;    // Blink pin, second stage
		logic [7:0]         rdData;   // Read answer
		logic               rdValid;  // Read answer marker
		logic [NUM_OUT-1:0] drv;      // Pin drive values, always low
		logic [NUM_OUT-1:0] oe;       // Pin sink enables
	} lpbi_state_t;

	// State of the timeslot counter
	typedef struct packed {
		logic [15:0] div;    // Oscillator divider
		logic        tick;   // Oscillator step marker
		logic [3:0]  slot;   // Timeslot index
		logic [3:0]  cycle;  // Cycle index within the timeslot
	} lpbi_cnt_t;

endpackage

/* File: lpbi_slot_counter.sv */
// Gated oscillator and wrapping timeslot and cycle counter
`timescale 1ns/1ps
module lpbi_slot_counter #(
	parameter int TICKS = lpbi_pkg::TICK_CYCLES  // Clocks per oscillator step
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Control
	input  wire logic       run,
	// Counter outputs
	output logic            tick,
	output logic [3:0]      slotIdx,
	output logic [3:0]      cycleIdx
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	lpbi_pkg::lpbi_cnt_t cntReg;   // Registered state
	lpbi_pkg::lpbi_cnt_t cntNext;  // Next state

	localparam logic [15:0] DIV_LAST = 16'(TICKS - 1);  // Divider wrap value

	// Oscillator stops while run is low to save power; counters hold
	always_comb begin
		cntNext      = cntReg;
		cntNext.tick = 1'b0;
		if (run) begin
			if (cntReg.div == DIV_LAST) begin
				cntNext.div  = '0;
				cntNext.tick = 1'b1;
				// One step of the 240-step period
				if (cntReg.cycle == lpbi_pkg::CYCLE_LAST) begin
					cntNext.cycle = '0;
					cntNext.slot  = (cntReg.slot == lpbi_pkg::SLOT_LAST) ? 4'h0 :
					                cntReg.slot + 4'h1;
				end else begin
					cntNext.cycle = cntReg.cycle + 4'h1;
				end
			end else begin
				cntNext.div = cntReg.div + 16'h0001;
			end
		end
	end

	// State register
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cntReg <= '0;
		end else begin
			cntReg <= cntNext;
		end
	end

	assign tick     = cntReg.tick;
	assign slotIdx  = cntReg.slot;
	assign cycleIdx = cntReg.cycle;

endmodule

/* File: lpbi_led_load.sv */
// Pull-up loads standing on the nine open-drain outputs
`timescale 1ns/1ps
module lpbi_led_load (
	// Pin control from the block
	input  wire logic [8:0] outDrv,
	input  wire logic [8:0] outOe,
	// Resolved pin levels
	output logic      [8:0] pinLevel
);
	// ----------------------------------------------------------------
	// Pin resolution
	// ----------------------------------------------------------------
	// A released pin floats up through its pull-up, a sinking pin shows the drive
	always_comb begin
		for (int k = 0; k < 9; k++) begin
			pinLevel[k] = outOe[k] ? outDrv[k] : 1'b1;
		end
	end
endmodule

/* File: led_pwm_blink_intensity_test.sv */
// Self-checking bench for the PWM intensity and blink level block
`timescale 1ns/1ps
module led_pwm_blink_intensity_test;
	// ----------------------------------------------------------------
	// Settings and signals
	// ----------------------------------------------------------------
	localparam int         TK    = 4;         // Shortened clocks per oscillator step
	localparam int         PER   = 240 * TK;  // Clocks in one PWM period
	localparam logic [7:0] PH0   = 8'h0F;     // Phase-zero levels used for PWM
	localparam logic [3:0] INTS[8] = '{4'h0, 4'hF, 4'h7, 4'hE, 4'h3, 4'h0, 4'hF, 4'h1};
	logic                mclk;             // System clock
	logic                rst;              // Asynchronous reset
	lpbi_pkg::lpbi_req_t req;              // Register request
	logic [7:0]          rdData;           // Read answer
	logic                rdValid;          // Read answer marker
	logic                blinkPin;         // Blink input
	logic [8:0]          outDrv;           // Pin drive
	logic [8:0]          outOe;            // Pin sink enable
	logic [8:0]          pinLevel;         // Resolved pin levels
	int                  fails;            // Mismatches
	int                  samples_checked;  // Comparisons
	int                  lowCnt[9];        // Low clocks per pin over a period

	// ----------------------------------------------------------------
	// Design and load
	// ----------------------------------------------------------------
	lpbi_core #(.TICKS(TK)) dut (.mclk(mclk), .rst(rst), .req(req), .rdData(rdData),
		.rdValid(rdValid), .blinkPin(blinkPin), .outDrv(outDrv), .outOe(outOe));
	lpbi_led_load load (.outDrv(outDrv), .outOe(outOe), .pinLevel(pinLevel));

	// Free-running clock
	always #10 mclk = ~mclk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	// Compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask

	// Counts, verdict and stop
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Wait six clocks so registered levels settle
	task automatic settle();
		repeat (6) @(posedge mclk);
		#2;
	endtask

	// One register write, strobe held over one sampling edge
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.data = d;
		@(posedge mclk);
		#2;
		req.wr = 1'b0;
		@(posedge mclk);
		#2;
	endtask

	// One register read with a bounded wait for the answer
	task automatic rdReg(input logic [7:0] a, input logic [7:0] exp);
		int n;
		n = 0;
		req.rd = 1'b1;
		req.addr = a;
		@(posedge mclk);
		#2;
		req.rd = 1'b0;
		while (rdValid !== 1'b1 && n < 3) begin
			@(posedge mclk);
			#2;
			n++;
		end
		if (rdValid !== 1'b1) begin
			fails++;
			$display("BAD %0t no read answer", $time);
			end_of_test();
		end
		check(rdData, exp);
		@(posedge mclk);
		#2;
	endtask

	// Sink clocks expected over one period for a gated slot count, intensity and level
	function automatic int sinkClks(input int m, input int it, input logic lvl);
		int on;
		on = (m == 0 || it == 15) ? 240 : m * (it + 1);
		return (lvl ? 240 - on : on) * TK;
	endfunction

	// Set master and mode, count low clocks on every pin over one period
	task automatic pwmCase(input logic [7:0] mst, input logic glb);
		int it;
		wrReg(lpbi_pkg::ADDR_CONFIG, {5'b00010, glb, 2'b00});
		wrReg(lpbi_pkg::ADDR_MASTER, mst);
		settle();
		foreach (lowCnt[k]) lowCnt[k] = 0;
		repeat (PER) begin
			@(posedge mclk);
			#2;
			for (int k = 0; k < 9; k++) begin
				if (pinLevel[k] === 1'b0) lowCnt[k]++;
			end
		end
		for (int k = 0; k < 9; k++) begin
			it = (glb || k == 8) ? int'(mst[3:0]) : int'(INTS[k]);
			check(lowCnt[k], sinkClks(mst[7:4], it, k == 8 ? 1'b1 : PH0[k]));
		end
		$display("Test PWM master %0h global %0b done", mst, glb);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		req = '0;
		blinkPin = 1'b0;
		fails = 0;
		samples_checked = 0;
		repeat (10) @(posedge mclk);
		#2;
		rst = 1'b0;
		@(posedge mclk);
		#2;
		// Reset values and an unmapped place
		check(outOe, 9'h000);
		check(outDrv, 9'h000);
		rdReg(lpbi_pkg::ADDR_PHASE0, 8'hFF);
		rdReg(lpbi_pkg::ADDR_PHASE1, 8'hFF);
		rdReg(lpbi_pkg::ADDR_MASTER, 8'h00);
		rdReg(lpbi_pkg::ADDR_CONFIG, 8'h30);
		rdReg(8'h05, 8'h00);
		$display("Test reset values done");
		// Static levels with blink off and both phases written
		wrReg(lpbi_pkg::ADDR_PHASE0, 8'hA5);
		rdReg(lpbi_pkg::ADDR_PHASE0, 8'hA5);
		wrReg(lpbi_pkg::ADDR_PHASE1, 8'h3C);
		rdReg(lpbi_pkg::ADDR_PHASE1, 8'h3C);
		settle();
		check(outOe, {1'b0, ~8'hA5});
		// Blink on, flip clear then set: pin XOR flip selects the phase; then blink off
		wrReg(lpbi_pkg::ADDR_CONFIG, 8'h11);
		settle();
		check(outOe, {1'b0, ~8'hA5});
		blinkPin = 1'b1;
		settle();
		check(outOe, {1'b1, ~8'h3C});
		wrReg(lpbi_pkg::ADDR_CONFIG, 8'h13);
		settle();
		check(outOe, {1'b0, ~8'hA5});
		wrReg(lpbi_pkg::ADDR_CONFIG, 8'h10);
		settle();
		check(outOe, {1'b0, ~8'hA5});
		blinkPin = 1'b0;
		$display("Test blink phases done");
		// PWM duty over whole periods, individual then global mode
		wrReg(lpbi_pkg::ADDR_PHASE0, PH0);
		for (int j = 0; j < 4; j++) begin
			wrReg(8'(lpbi_pkg::ADDR_INT_BASE + j), {INTS[2*j+1], INTS[2*j]});
		end
		pwmCase(8'h0A, 1'b0);
		pwmCase(8'h12, 1'b0);
		pwmCase(8'hFE, 1'b0);
		pwmCase(8'h75, 1'b1);
		pwmCase(8'h3F, 1'b1);
		end_of_test();
	end
endmodule
